/* sim/brake_actuator.sv */
// Brake actuator model answering the release request after a lag
`timescale 1ns/1ps
`default_nettype none
module brake_actuator #(
  parameter int LAG = 4
) (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic request_in,
  input wire logic stuck_in,
  output logic feedback_out
);
  int cnt_reg;
  // Feedback follows a steady request after LAG+1 cycles; stuck never opens
  always_ff @(posedge sys_clk_in) begin
    if (srst_in || stuck_in) begin
      cnt_reg <= 0;
      feedback_out <= 1'b0;
    end else if (request_in == feedback_out) begin
      cnt_reg <= 0;
    end else if (cnt_reg == LAG) begin
      cnt_reg <= 0;
      feedback_out <= request_in;
    end else begin
      cnt_reg <= cnt_reg + 1;
    end
  end
endmodule : brake_actuator
`default_nettype wire

/* sim/speed_brake_ctrl_tb.sv */
// Bench for the speed select and brake sequence block
`timescale 1ns/1ps
`default_nettype none
module speed_brake_ctrl_tb;
  localparam int TC = 5;
  logic clk = 1'b0, srst = 1'b1, h = 1'b0, m = 1'b0, l = 1'b0, s = 1'b0;
  logic j = 1'b0, wr = 1'b0, start = 1'b0, enc = 1'b0, dec = 1'b0;
  logic abn = 1'b0, clr = 1'b0, stuck = 1'b0, fb;
  logic [1:0] cs = 2'h0, rs = 2'h0;
  logic [3:0] sel = 4'h0;
  logic [15:0] data = 16'h0, spd = 16'h0, ofr = 16'h0, dfr = 16'h0;
  logic [15:0] cur = 16'h0;
  brake_pkg::freq_src_e src;
  brake_pkg::accel_mode_e am;
  logic soc, rej, req, hold, ovf, tof, dcf, es;
  logic [4:0] v;
  int i, k, mismatches = 0, n_tests = 0;
  // Clock at 50 MHz
  always #10 clk = ~clk;
  speed_brake_ctrl #(.TICK_CYCLES(TC)) dut (.sys_clk_in(clk),
    .srst_in(srst), .high_speed_in(h), .middle_speed_in(m),
    .low_speed_in(l), .second_function_in(s), .jog_in(j),
    .contact_sel_in(cs), .remote_sel_in(rs), .cfg_wr_in(wr),
    .cfg_sel_in(sel), .cfg_data_in(data), .start_in(start),
    .speed_cmd_in(spd), .out_freq_in(ofr), .detect_freq_in(dfr),
    .current_in(cur), .encoder_fb_in(enc), .decelerating_in(dec),
    .decel_abnormal_in(abn), .brake_release_feedback_in(fb),
    .fault_clear_in(clr), .freq_src_out(src), .stop_on_contact_out(soc),
    .accel_mode_out(am), .cfg_reject_out(rej),
    .brake_release_request_out(req), .accel_hold_out(hold),
    .overspeed_fault_out(ovf), .release_timeout_fault_out(tof),
    .decel_fault_out(dcf));
  brake_actuator act (.sys_clk_in(clk), .srst_in(srst),
    .request_in(req), .stuck_in(stuck), .feedback_out(fb));
  // Expected source from the input levels {h,m,l,s,j}
  function automatic brake_pkg::freq_src_e exp_src(input logic [4:0] x);
    if (x[0]) return brake_pkg::SRC_JOG;
    if (x[2] && x[1]) return brake_pkg::SRC_LOW;
    if (x[4] && x[3] && x[2]) return brake_pkg::SRC_SPEED7;
    if (x[4] && x[3]) return brake_pkg::SRC_SPEED6;
    if (x[4] && x[2]) return brake_pkg::SRC_SPEED5;
    if (x[3] && x[2]) return brake_pkg::SRC_SPEED4;
    if (x[4]) return brake_pkg::SRC_HIGH;
    if (x[3]) return brake_pkg::SRC_MIDDLE;
    if (x[2]) return brake_pkg::SRC_LOW;
    return brake_pkg::SRC_ANALOG;
  endfunction : exp_src
  // Expected decode of a mode code; invalid codes are refused
  function automatic brake_pkg::accel_mode_e exp_acc(input int c);
    case (c)
      0: return brake_pkg::ACC_MODE_NORMAL;
      1, 11: return brake_pkg::ACC_MODE_SHORTEST;
      3: return brake_pkg::ACC_MODE_OPTIMUM;
      5, 6: return brake_pkg::ACC_MODE_ELEVATOR;
      7: return brake_pkg::ACC_MODE_BRAKE_FB;
      8: return brake_pkg::ACC_MODE_BRAKE_NOFB;
      default: return brake_pkg::ACC_MODE_INVALID;
    endcase
  endfunction : exp_acc
  task automatic check(input string what, input logic [15:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  // Reset for 8 cycles with the sequence inputs idle
  task automatic rst();
    @(posedge clk);
    srst <= 1'b1;
    start <= 1'b0;
    stuck <= 1'b0;
    clr <= 1'b0;
    dec <= 1'b0;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
  endtask : rst
  // One setting write, then watch for a refusal pulse
  task automatic cfg(input logic [3:0] c, input logic [15:0] d, input logic r);
    logic seen;
    seen = 1'b0;
    @(posedge clk);
    wr <= 1'b1;
    sel <= c;
    data <= d;
    @(posedge clk);
    wr <= 1'b0;
    repeat (3) begin
      @(negedge clk);
      seen = seen | rej;
    end
    check("cfg_reject", {15'h0, seen}, {15'h0, r});
  endtask : cfg
  // Brake sequence start: speed above opening, current from the argument
  task automatic go(input logic [15:0] c);
    @(posedge clk);
    spd <= 16'h0032;
    cur <= c;
    start <= 1'b1;
  endtask : go
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_sim();
  end
  // Main sequence
  initial begin
    void'($urandom(32'h04b1));
    rst();
    @(negedge clk);
    check("accel_mode reset", am, brake_pkg::ACC_MODE_NORMAL);
    for (i = 0; i < 200; i++) begin
      v = (i < 32) ? i[4:0] : 5'($urandom);
      @(posedge clk);
      {h, m, l, s, j} <= v;
      cs <= 2'($urandom);
      rs <= (i < 32) ? 2'h0 : 2'($urandom);
      @(posedge clk);
      @(negedge clk);
      check("src", src, exp_src(v));
      es = (cs == 2'h1 || cs == 2'h3) && rs == 2'h0 && !j && l && s;
      check("stop_on_contact", soc, {15'h0, es});
    end
    $display("test selector done");
    cfg(4'h0, 16'h012d, 1'b1);
    cfg(4'h0, 16'h003d, 1'b1);
    cfg(4'h0, 16'h0014, 1'b0);
    cfg(4'h4, 16'h0013, 1'b1);
    cfg(4'h4, 16'h012c, 1'b0);
    cfg(4'h1, 16'h00dd, 1'b1);
    cfg(4'h1, 16'h0046, 1'b0);
    cfg(4'h2, 16'h00c9, 1'b1);
    cfg(4'h3, 16'h01f5, 1'b1);
    cfg(4'h5, 16'h01f5, 1'b1);
    cfg(4'h7, 16'h012d, 1'b1);
    cfg(4'h7, 16'h270f, 1'b0);
    cfg(4'h6, 16'h0002, 1'b1);
    for (k = 0; k < 13; k++) begin
      cfg(4'h8, 16'(k), exp_acc(k) == brake_pkg::ACC_MODE_INVALID);
      if (exp_acc(k) != brake_pkg::ACC_MODE_INVALID)
        check("accel_mode", am, exp_acc(k));
    end
    $display("test settings done");
    rst();
    cfg(4'h2, 16'h0004, 1'b0);
    cfg(4'h3, 16'h0000, 1'b0);
    cfg(4'h8, 16'h0008, 1'b0);
    go(16'h0096);
    repeat (10) @(negedge clk);
    check("request early", req, 16'h0);
    for (i = 0; i < 40 && req !== 1'b1; i++) @(negedge clk);
    check("request", req, 16'h1);
    for (i = 0; i < 20 && hold !== 1'b0; i++) @(negedge clk);
    check("hold", hold, 16'h0);
    @(posedge clk);
    dec <= 1'b1;
    repeat (4) @(negedge clk);
    check("request stop", req, 16'h0);
    $display("test sequence without feedback done");
    rst();
    cfg(4'h3, 16'h0002, 1'b0);
    cfg(4'h2, 16'h0000, 1'b0);
    cfg(4'h8, 16'h0007, 1'b0);
    go(16'h0096);
    for (i = 0; i < 40 && req !== 1'b1; i++) @(negedge clk);
    check("hold before feedback", hold, 16'h1);
    for (i = 0; i < 60 && hold !== 1'b0; i++) @(negedge clk);
    check("hold after feedback", hold, 16'h0);
    @(posedge clk);
    start <= 1'b0;
    repeat (4) @(negedge clk);
    check("request off", req, 16'h0);
    rst();
    cfg(4'h8, 16'h0007, 1'b0);
    @(posedge clk);
    stuck <= 1'b1;
    go(16'h0096);
    for (i = 0; i < 1200 && tof !== 1'b1; i++) @(negedge clk);
    check("feedback timeout", tof, 16'h1);
    check("request dropped", req, 16'h0);
    $display("test sequence with feedback done");
    rst();
    cfg(4'h8, 16'h0008, 1'b0);
    go(16'h0000);
    repeat (900) @(negedge clk);
    check("request low current", req, 16'h0);
    check("timeout early", tof, 16'h0);
    for (i = 0; i < 300 && tof !== 1'b1; i++) @(negedge clk);
    check("start timeout", tof, 16'h1);
    @(posedge clk);
    start <= 1'b0;
    clr <= 1'b1;
    repeat (3) @(negedge clk);
    check("timeout cleared", tof, 16'h0);
    $display("test timeouts done");
    rst();
    enc <= 1'b1;
    ofr <= 16'h0064;
    dfr <= 16'h00c8;
    dec <= 1'b1;
    abn <= 1'b1;
    repeat (5) @(negedge clk);
    check("overspeed off", ovf, 16'h0);
    check("decel off", dcf, 16'h0);
    @(posedge clk);
    dfr <= 16'h0095;
    cfg(4'h7, 16'h0032, 1'b0);
    check("overspeed below", ovf, 16'h0);
    @(posedge clk);
    dfr <= 16'h0096;
    cfg(4'h6, 16'h0001, 1'b0);
    check("overspeed", ovf, 16'h1);
    check("decel fault", dcf, 16'h1);
    $display("test faults done");
    end_sim();
  end
endmodule : speed_brake_ctrl_tb
`default_nettype wire

/* verilog/brake_params.svh */
// Constants for the speed select and brake sequence block
// Contract
// - Stop-on-contact valid only for contact selection one or three.
// - Jog input always selects jog frequency, whatever else is asserted.
// - Without jog, low speed plus second function selects low-speed preset.
// - No speed input, or second function only, selects the analog command.
// - Middle speed alone, with or without second function, selects middle.
// - High plus middle without low or jog selects speed-6 preset.
// - High plus low alone selects speed-5 preset.
// - Middle plus low alone selects speed-4 preset.
// - High, middle and low without second function or jog select speed-7.
// - Remote setting selection one to three disables stop-on-contact.
// - Opening frequency 0 to 30 Hz, default 3 Hz, not above closing.
// - Opening current threshold 0 to 220 percent, default 130 percent.
// - Opening current detection time 0 to 2 s, default 0.3 s.
// - Start brake delay 0 to 5 s, default 0.3 s.
// - Closing frequency 0 to 30 Hz, default 6 Hz, not below opening.
// - Stop brake delay 0 to 5 s, default 0.3 s.
// - Deceleration check off at zero; at one abnormal deceleration faults.
// - Encoder overspeed faults when deviation reaches threshold; 9999 off.
// - Acceleration mode decode: 0,1/11,3,5/6,7,8; default 0.
// - Low speed with second function enters stop-on-contact, any order.
// - Request after detection time once frequency and current are reached.
// - Trip if request or feedback missing 2 s after start or request.
`ifndef BRAKE_PARAMS_SVH
`define BRAKE_PARAMS_SVH
// Clock and time base
`define CLK_PERIOD_NS 20
`define TICK_PERIOD_NS 10000000
`define TICK_PERIOD_MS 10
`define TICK_CYCLES (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define RELEASE_TIMEOUT_MS 2000
`define RELEASE_TIMEOUT_TICKS 16'(`RELEASE_TIMEOUT_MS / `TICK_PERIOD_MS)
// Setting limits and defaults: frequency 0.1 Hz, current %, time 10 ms
`define FREQ_MAX 16'h012c
`define OPEN_FREQ_DEF 16'h001e
`define CLOSE_FREQ_DEF 16'h003c
`define CUR_MAX 16'h00dc
`define CUR_DEF 16'h0082
`define DETECT_MAX 16'h00c8
`define DELAY_MAX 16'h01f4
`define TIME_DEF 16'h001e
`define OVS_OFF 16'h270f
`define DECEL_SEL_ON 16'h0001
// Selection codes
`define CONTACT_SEL_A 2'h1
`define CONTACT_SEL_B 2'h3
`define REMOTE_MIN 2'h1
`define REMOTE_MAX 2'h3
`define CFG_OPEN_FREQ 4'h0
`define CFG_OPEN_CUR 4'h1
`define CFG_DETECT 4'h2
`define CFG_START_DLY 4'h3
`define CFG_CLOSE_FREQ 4'h4
`define CFG_STOP_DLY 4'h5
`define CFG_DECEL_SEL 4'h6
`define CFG_OVS 4'h7
`define CFG_ACCEL 4'h8
`define ACC_NORMAL 16'h0000
`define ACC_SHORT_A 16'h0001
`define ACC_SHORT_B 16'h000b
`define ACC_OPTIMUM 16'h0003
`define ACC_ELEV_A 16'h0005
`define ACC_ELEV_B 16'h0006
`define ACC_BRAKE_FB 16'h0007
`define ACC_BRAKE_NOFB 16'h0008
`endif

/* verilog/brake_pkg.sv */
// Types for the speed select and brake sequence block
package brake_pkg;
  typedef enum logic [3:0] {
    SRC_ANALOG = 4'h0, SRC_HIGH = 4'h1, SRC_MIDDLE = 4'h2, SRC_LOW = 4'h3,
    SRC_SPEED4 = 4'h4, SRC_SPEED5 = 4'h5, SRC_SPEED6 = 4'h6,
    SRC_SPEED7 = 4'h7, SRC_JOG = 4'h8
  } freq_src_e;
  typedef enum logic [2:0] {
    ACC_MODE_NORMAL = 3'h0, ACC_MODE_SHORTEST = 3'h1,
    ACC_MODE_OPTIMUM = 3'h2, ACC_MODE_ELEVATOR = 3'h3,
    ACC_MODE_BRAKE_FB = 3'h4, ACC_MODE_BRAKE_NOFB = 3'h5,
    ACC_MODE_INVALID = 3'h6
  } accel_mode_e;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_DETECT = 3'h1, ST_WAIT = 3'h3, ST_RUN = 3'h2,
    ST_STOPPING = 3'h6, ST_FAULT = 3'h4
  } brake_state_e;
endpackage : brake_pkg

/* verilog/speed_brake_ctrl.sv */
// Speed source selector and mechanical brake sequence supervisor
`timescale 1ns/1ps
`default_nettype none
`include "brake_params.svh"
module speed_brake_ctrl #(
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic high_speed_in,
  input wire logic middle_speed_in,
  input wire logic low_speed_in,
  input wire logic second_function_in,
  input wire logic jog_in,
  input wire logic [1:0] contact_sel_in,
  input wire logic [1:0] remote_sel_in,
  input wire logic cfg_wr_in,
  input wire logic [3:0] cfg_sel_in,
  input wire logic [15:0] cfg_data_in,
  input wire logic start_in,
  input wire logic [15:0] speed_cmd_in,
  input wire logic [15:0] out_freq_in,
  input wire logic [15:0] detect_freq_in,
  input wire logic [15:0] current_in,
  input wire logic encoder_fb_in,
  input wire logic decelerating_in,
  input wire logic decel_abnormal_in,
  input wire logic brake_release_feedback_in,
  input wire logic fault_clear_in,
  output brake_pkg::freq_src_e freq_src_out,
  output logic stop_on_contact_out,
  output brake_pkg::accel_mode_e accel_mode_out,
  output logic cfg_reject_out,
  output logic brake_release_request_out,
  output logic accel_hold_out,
  output logic overspeed_fault_out,
  output logic release_timeout_fault_out,
  output logic decel_fault_out
);
  logic [15:0] open_freq_reg, open_cur_reg, detect_reg, start_dly_reg;
  logic [15:0] close_freq_reg, stop_dly_reg, decel_sel_reg, ovs_reg;
  logic [15:0] accel_sel_reg;
  brake_pkg::brake_state_e state_reg, state_next;
  logic tick;
  logic det_done, start_done, stop_done, req_late, fb_late;

  // Time base for all sequence timers
  tick_divider #(.CYCLES(TICK_CYCLES)) u_tick (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .tick_out(tick)
  );

  // Stop-on-contact qualification
  wire contact_sel = (contact_sel_in == `CONTACT_SEL_A) ||
                     (contact_sel_in == `CONTACT_SEL_B);
  wire remote_on = (remote_sel_in >= `REMOTE_MIN) &&
                   (remote_sel_in <= `REMOTE_MAX);
  wire contact_next = contact_sel && !remote_on && !jog_in &&
                      low_speed_in && second_function_in;

  // Frequency source decode from the present input levels
  wire h = high_speed_in;
  wire m = middle_speed_in;
  wire l = low_speed_in;
  wire t = second_function_in;
  brake_pkg::freq_src_e src_next;
  assign src_next =
    jog_in ? brake_pkg::SRC_JOG :
    (l && t) ? brake_pkg::SRC_LOW :
    (h && m && l) ? brake_pkg::SRC_SPEED7 :
    (h && m) ? brake_pkg::SRC_SPEED6 :
    (h && l) ? brake_pkg::SRC_SPEED5 :
    (m && l) ? brake_pkg::SRC_SPEED4 :
    h ? brake_pkg::SRC_HIGH :
    m ? brake_pkg::SRC_MIDDLE :
    l ? brake_pkg::SRC_LOW :
    brake_pkg::SRC_ANALOG;

  // Selector outputs registered every cycle, nothing latched
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      freq_src_out <= brake_pkg::SRC_ANALOG;
      stop_on_contact_out <= 1'b0;
    end else begin
      freq_src_out <= src_next;
      stop_on_contact_out <= contact_next;
    end
  end

  // Acceptance checks for setting writes
  wire [15:0] d = cfg_data_in;
  wire ok_open = (d <= `FREQ_MAX) && (d <= close_freq_reg);
  wire ok_close = (d <= `FREQ_MAX) && (d >= open_freq_reg);
  wire ok_cur = (d <= `CUR_MAX);
  wire ok_det = (d <= `DETECT_MAX);
  wire ok_dly = (d <= `DELAY_MAX);
  wire ok_dec = (d <= `DECEL_SEL_ON);
  wire ok_ovs = (d <= `FREQ_MAX) || (d == `OVS_OFF);
  wire ok_acc = (d == `ACC_NORMAL) || (d == `ACC_SHORT_A) ||
                (d == `ACC_SHORT_B) || (d == `ACC_OPTIMUM) ||
                (d == `ACC_ELEV_A) || (d == `ACC_ELEV_B) ||
                (d == `ACC_BRAKE_FB) || (d == `ACC_BRAKE_NOFB);
  wire sel_ok =
    (cfg_sel_in == `CFG_OPEN_FREQ) ? ok_open :
    (cfg_sel_in == `CFG_OPEN_CUR) ? ok_cur :
    (cfg_sel_in == `CFG_DETECT) ? ok_det :
    (cfg_sel_in == `CFG_START_DLY) ? ok_dly :
    (cfg_sel_in == `CFG_CLOSE_FREQ) ? ok_close :
    (cfg_sel_in == `CFG_STOP_DLY) ? ok_dly :
    (cfg_sel_in == `CFG_DECEL_SEL) ? ok_dec :
    (cfg_sel_in == `CFG_OVS) ? ok_ovs :
    (cfg_sel_in == `CFG_ACCEL) ? ok_acc : 1'b0;
  wire wr = cfg_wr_in && sel_ok;

  // Setting storage with documented defaults
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      open_freq_reg <= `OPEN_FREQ_DEF;
      open_cur_reg <= `CUR_DEF;
      detect_reg <= `TIME_DEF;
      start_dly_reg <= `TIME_DEF;
      close_freq_reg <= `CLOSE_FREQ_DEF;
      stop_dly_reg <= `TIME_DEF;
      decel_sel_reg <= 16'h0;
      ovs_reg <= `OVS_OFF;
      accel_sel_reg <= `ACC_NORMAL;
    end else if (wr) begin
      case (cfg_sel_in)
        `CFG_OPEN_FREQ: open_freq_reg <= d;
        `CFG_OPEN_CUR: open_cur_reg <= d;
        `CFG_DETECT: detect_reg <= d;
        `CFG_START_DLY: start_dly_reg <= d;
        `CFG_CLOSE_FREQ: close_freq_reg <= d;
        `CFG_STOP_DLY: stop_dly_reg <= d;
        `CFG_DECEL_SEL: decel_sel_reg <= d;
        `CFG_OVS: ovs_reg <= d;
        `CFG_ACCEL: accel_sel_reg <= d;
        default: ;
      endcase
    end
  end

  // Acceleration mode decode
  brake_pkg::accel_mode_e acc_next;
  assign acc_next =
    (accel_sel_reg == `ACC_NORMAL) ? brake_pkg::ACC_MODE_NORMAL :
    (accel_sel_reg == `ACC_SHORT_A || accel_sel_reg == `ACC_SHORT_B) ?
      brake_pkg::ACC_MODE_SHORTEST :
    (accel_sel_reg == `ACC_OPTIMUM) ? brake_pkg::ACC_MODE_OPTIMUM :
    (accel_sel_reg == `ACC_ELEV_A || accel_sel_reg == `ACC_ELEV_B) ?
      brake_pkg::ACC_MODE_ELEVATOR :
    (accel_sel_reg == `ACC_BRAKE_FB) ? brake_pkg::ACC_MODE_BRAKE_FB :
    (accel_sel_reg == `ACC_BRAKE_NOFB) ? brake_pkg::ACC_MODE_BRAKE_NOFB :
    brake_pkg::ACC_MODE_INVALID;
  wire mode_fb = (accel_sel_reg == `ACC_BRAKE_FB);
  wire brake_mode = mode_fb || (accel_sel_reg == `ACC_BRAKE_NOFB);

  // Sequence conditions
  wire req_on = (state_reg == brake_pkg::ST_WAIT) ||
                (state_reg == brake_pkg::ST_RUN);
  wire open_cond = (speed_cmd_in >= open_freq_reg) &&
                   (current_in >= open_cur_reg);
  wire fb_ok = !mode_fb || brake_release_feedback_in;
  wire fb_gone = !mode_fb || !brake_release_feedback_in;
  wire [16:0] ovs_sum = {1'b0, out_freq_in} + {1'b0, ovs_reg};
  wire ovs_hit = encoder_fb_in && (ovs_reg != `OVS_OFF) &&
                 ({1'b0, detect_freq_in} >= ovs_sum);
  wire dec_hit = (decel_sel_reg == `DECEL_SEL_ON) && decelerating_in &&
                 decel_abnormal_in;
  wire late_hit = brake_mode && (req_late || fb_late);
  wire any_fault = ovs_hit || dec_hit || late_hit;

  // Sequence timers
  tick_timer u_det (.sys_clk_in(sys_clk_in), .srst_in(srst_in),
    .run_in(state_reg == brake_pkg::ST_DETECT && open_cond),
    .tick_in(tick), .limit_in(detect_reg), .done_out(det_done));
  tick_timer u_start (.sys_clk_in(sys_clk_in), .srst_in(srst_in),
    .run_in(state_reg == brake_pkg::ST_WAIT && fb_ok),
    .tick_in(tick), .limit_in(start_dly_reg), .done_out(start_done));
  tick_timer u_stop (.sys_clk_in(sys_clk_in), .srst_in(srst_in),
    .run_in(state_reg == brake_pkg::ST_STOPPING && fb_gone),
    .tick_in(tick), .limit_in(stop_dly_reg), .done_out(stop_done));
  tick_timer u_req (.sys_clk_in(sys_clk_in), .srst_in(srst_in),
    .run_in(start_in && !req_on && state_reg != brake_pkg::ST_FAULT),
    .tick_in(tick), .limit_in(`RELEASE_TIMEOUT_TICKS),
    .done_out(req_late));
  tick_timer u_fb (.sys_clk_in(sys_clk_in), .srst_in(srst_in),
    .run_in(req_on && mode_fb && !brake_release_feedback_in),
    .tick_in(tick), .limit_in(`RELEASE_TIMEOUT_TICKS),
    .done_out(fb_late));

  // Next-state logic of the brake sequence
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      brake_pkg::ST_IDLE:
        if (brake_mode && start_in) state_next = brake_pkg::ST_DETECT;
      brake_pkg::ST_DETECT:
        if (!start_in) state_next = brake_pkg::ST_IDLE;
        else if (det_done) state_next = brake_pkg::ST_WAIT;
      brake_pkg::ST_WAIT:
        if (!start_in) state_next = brake_pkg::ST_STOPPING;
        else if (start_done) state_next = brake_pkg::ST_RUN;
      brake_pkg::ST_RUN:
        if (!start_in || (decelerating_in &&
            out_freq_in <= close_freq_reg))
          state_next = brake_pkg::ST_STOPPING;
      brake_pkg::ST_STOPPING:
        if (stop_done) state_next = brake_pkg::ST_IDLE;
      brake_pkg::ST_FAULT:
        if (fault_clear_in && !start_in) state_next = brake_pkg::ST_IDLE;
      default: state_next = brake_pkg::ST_IDLE;
    endcase
    if (any_fault) state_next = brake_pkg::ST_FAULT;
  end

  wire req_next = (state_next == brake_pkg::ST_WAIT) ||
                  (state_next == brake_pkg::ST_RUN);
  wire hold_next = start_in && brake_mode &&
                   (state_next != brake_pkg::ST_RUN);

  // Sequence state and its outputs
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      state_reg <= brake_pkg::ST_IDLE;
      brake_release_request_out <= 1'b0;
      accel_hold_out <= 1'b0;
      accel_mode_out <= brake_pkg::ACC_MODE_NORMAL;
      cfg_reject_out <= 1'b0;
    end else begin
      state_reg <= state_next;
      brake_release_request_out <= req_next;
      accel_hold_out <= hold_next;
      accel_mode_out <= acc_next;
      cfg_reject_out <= cfg_wr_in && !sel_ok;
    end
  end

  // Sticky fault flags; a new event wins over a clear
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      overspeed_fault_out <= 1'b0;
      release_timeout_fault_out <= 1'b0;
      decel_fault_out <= 1'b0;
    end else begin
      overspeed_fault_out <= ovs_hit ||
        (overspeed_fault_out && !fault_clear_in);
      release_timeout_fault_out <= late_hit ||
        (release_timeout_fault_out && !fault_clear_in);
      decel_fault_out <= dec_hit ||
        (decel_fault_out && !fault_clear_in);
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);

  a_jog_priority: assert property (jog_in |=>
    freq_src_out == brake_pkg::SRC_JOG) else $error("jog not selected");
  a_low_second: assert property (!jog_in && l && t |=>
    freq_src_out == brake_pkg::SRC_LOW) else $error("low not selected");
  a_analog_idle: assert property (!jog_in && !h && !m && !l |=>
    freq_src_out == brake_pkg::SRC_ANALOG) else $error("analog missed");
  a_middle_only: assert property (!jog_in && !h && m && !l |=>
    freq_src_out == brake_pkg::SRC_MIDDLE) else $error("middle missed");
  a_speed_six: assert property (!jog_in && h && m && !l |=>
    freq_src_out == brake_pkg::SRC_SPEED6) else $error("speed6 missed");
  a_speed_five: assert property (!jog_in && h && !m && l && !t |=>
    freq_src_out == brake_pkg::SRC_SPEED5) else $error("speed5 missed");
  a_speed_four: assert property (!jog_in && !h && m && l && !t |=>
    freq_src_out == brake_pkg::SRC_SPEED4) else $error("speed4 missed");
  a_speed_seven: assert property (!jog_in && h && m && l && !t |=>
    freq_src_out == brake_pkg::SRC_SPEED7) else $error("speed7 missed");
  a_contact_sel: assert property (!contact_sel |=>
    !stop_on_contact_out) else $error("contact without selection");
  a_contact_remote: assert property (remote_on |=>
    !stop_on_contact_out) else $error("contact under remote");
  a_contact_enter: assert property (contact_next |=>
    stop_on_contact_out) else $error("contact mode not entered");
  a_freq_order: assert property (open_freq_reg <= close_freq_reg &&
    close_freq_reg <= `FREQ_MAX) else $error("brake freq order broken");
  a_cur_range: assert property (open_cur_reg <= `CUR_MAX)
    else $error("current threshold out of range");
  a_time_range: assert property (detect_reg <= `DETECT_MAX &&
    start_dly_reg <= `DELAY_MAX && stop_dly_reg <= `DELAY_MAX)
    else $error("brake time out of range");
  a_req_after_detect: assert property ($rose(brake_release_request_out)
    |-> $past(state_reg) == brake_pkg::ST_DETECT && $past(det_done))
    else $error("request without detection");
  a_overspeed_trip: assert property (ovs_hit |=>
    overspeed_fault_out && !brake_release_request_out)
    else $error("overspeed not flagged");
  a_decel_trip: assert property (decel_sel_reg == 16'h0 &&
    !decel_fault_out |=> !decel_fault_out) else $error("decel check on");
  a_timeout_trip: assert property (late_hit |=>
    release_timeout_fault_out && state_reg == brake_pkg::ST_FAULT)
    else $error("timeout not flagged");
  a_accel_decode: assert property (accel_sel_reg == `ACC_BRAKE_FB |=>
    accel_mode_out == brake_pkg::ACC_MODE_BRAKE_FB)
    else $error("accel mode decode wrong");

  c_contact: cover property (stop_on_contact_out);
  c_release: cover property ($rose(brake_release_request_out));
  c_run_stop: cover property (state_reg == brake_pkg::ST_STOPPING
    ##1 state_reg == brake_pkg::ST_IDLE);
  c_timeout: cover property ($rose(release_timeout_fault_out));
endmodule : speed_brake_ctrl
`default_nettype wire

/* verilog/tick_divider.sv */
// Divider producing a one-cycle time-base enable pulse
`timescale 1ns/1ps
`default_nettype none
module tick_divider #(
  parameter int CYCLES = 500000
) (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  output logic tick_out
);
  logic [31:0] count_reg;
  wire at_end = (count_reg == 32'(CYCLES - 1));

  // Free-running count, pulse on wrap
  always_ff @(posedge sys_clk_in) begin
    if (srst_in || at_end) count_reg <= 32'h0;
    else count_reg <= count_reg + 32'h1;
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) tick_out <= 1'b0;
    else tick_out <= at_end;
  end
endmodule : tick_divider
`default_nettype wire

/* verilog/tick_timer.sv */
// Saturating tick counter that flags when its limit is reached
`timescale 1ns/1ps
`default_nettype none
module tick_timer (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic run_in,
  input wire logic tick_in,
  input wire logic [15:0] limit_in,
  output logic done_out
);
  logic [15:0] count_reg;
  wire reached = (count_reg >= limit_in);

  // Count ticks while running; cleared whenever run drops
  always_ff @(posedge sys_clk_in) begin
    if (srst_in || !run_in) count_reg <= 16'h0;
    else if (tick_in && !reached) count_reg <= count_reg + 16'h1;
  end

  assign done_out = run_in && reached;
endmodule : tick_timer
`default_nettype wire
